/* File: bench/cbc_ctrl_regs_tb_top.sv */
/*
 * Self-checking bench of the control front end, one task per scenario.
 * Assumes the far-side model and a registered read port with one-cycle latency.
 */
`timescale 1ns/1ps
module cbc_ctrl_regs_tb_top;
	logic mclk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, claim_load = 1'b0, bus_idle = 1'b0;
	logic frame_end = 1'b0, frame_own = 1'b0, frame_ok = 1'b0, raw_line = 1'b1;
	logic [7:0] reg_addr = 8'h00, header_byte = 8'h00;
	logic [3:0] reg_be = 4'hF, claim_index = 4'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, r;
	logic tx_port_ready, header_to_us, block_active, clock_gate_n, engine_reset, follower_enable;
	logic line_filtered, tx_valid, tx_ready, rx_valid, rx_ready, receive_fifo_not_empty, ok;
	logic [2:0] signal_free_time;
	cbc_pkg::cbc_block_s tx_block, rx_block;
	int n_mismatch = 0, samples_checked = 0;
	cbc_ctrl_regs i_cbc_ctrl_regs (.mclk, .nrst, .reg_wr, .reg_rd, .reg_addr, .reg_be, .reg_wdata, .reg_rdata,
		.tx_port_ready, .claim_load, .claim_index, .header_byte, .header_to_us, .bus_idle, .frame_end,
		.frame_own, .frame_ok, .raw_line, .block_active, .clock_gate_n, .engine_reset, .follower_enable,
		.line_filtered, .signal_free_time, .tx_valid, .tx_ready, .tx_block, .rx_valid, .rx_ready, .rx_block,
		.receive_fifo_not_empty);
	cbc_far_model i_cbc_far_model (.mclk, .nrst, .tx_valid, .tx_ready, .tx_block, .rx_valid, .rx_ready, .rx_block);
	// 40 MHz clock
	initial begin
		forever #12.5 mclk = ~mclk;
	end
	task automatic step(input int n = 1);
		repeat (n) @(posedge mclk);
		#2;
	endtask : step
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		reg_addr = a;
		reg_be = be;
		reg_wdata = d;
		reg_wr = 1'b1;
		step();
		reg_wr = 1'b0;
		step();
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [3:0] be = 4'hF);
		reg_addr = a;
		reg_be = be;
		reg_rd = 1'b1;
		step();
		reg_rd = 1'b0;
		r = reg_rdata;
		step();
	endtask : rd
	task automatic results;
		$display("comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : results
	task automatic t_reset;
		rd(8'h00);
		chk(r, 32'h0);
		rd(8'h04);
		chk(r, 32'h0);
		chk(signal_free_time, 32'h5);
		chk(tx_port_ready, 32'h1);
	endtask : t_reset
	task automatic t_ctrl;
		wr(8'h00, 4'hF, 32'h5);
		rd(8'h00);
		chk(r, 32'h5);
		chk(block_active, 32'h1);
		raw_line = 1'b0;
		step(8);
		chk(line_filtered, 32'h0);
		raw_line = 1'b1;
		step(2);
		raw_line = 1'b0;
		step(8);
		chk(line_filtered, 32'h0);
		wr(8'h00, 4'hF, 32'h1);
		raw_line = 1'b1;
		step(3);
		chk(line_filtered, 32'h1);
	endtask : t_ctrl
	task automatic t_claim;
		chk(follower_enable, 32'h0);
		claim_index = 4'h3;
		claim_load = 1'b1;
		step();
		claim_load = 1'b0;
		rd(8'h04);
		chk(r, 32'h8);
		header_byte = 8'h23;
		step();
		chk(header_to_us, 32'h1);
		header_byte = 8'h45;
		step();
		chk(header_to_us, 32'h0);
		header_byte = 8'h3F;
		step();
		chk(header_to_us, 32'h1);
		chk(follower_enable, 32'h1);
	endtask : t_claim
	task automatic t_tx;
		int n;
		i_cbc_far_model.stall = 1'b1;
		for (int i = 0; i < 16; i++) wr(8'h08, 4'hF, {23'h0, i == 15, 8'(i)});
		chk(tx_port_ready, 32'h0);
		wr(8'h08, 4'hF, 32'h1EE);
		rd(8'h08);
		chk(r, 32'h0);
		i_cbc_far_model.stall = 1'b0;
		wr(8'h08, 4'h2, 32'h100);
		wr(8'h08, 4'h1, 32'h0CD);
		n = 0;
		while (i_cbc_far_model.got.size() < 17 && n < 100) begin
			step();
			n++;
		end
		if (i_cbc_far_model.got.size() < 17) begin
			n_mismatch++;
			$display("mismatch at %0t: transmit drain timed out", $time);
			results();
		end
		step(4);
		chk(i_cbc_far_model.got.size(), 32'd17);
		chk(i_cbc_far_model.got[0], 32'h000);
		chk(i_cbc_far_model.got[15], 32'h10F);
		chk(i_cbc_far_model.got[16], 32'h1CD);
	endtask : t_tx
	task automatic t_rx;
		i_cbc_far_model.send(9'h15A, ok);
		chk(ok, 32'h1);
		i_cbc_far_model.send(9'h0C3, ok);
		chk(receive_fifo_not_empty, 32'h1);
		rd(8'h0C);
		chk(r, 32'h15A);
		rd(8'h0C, 4'h2);
		chk(r[8:0], 32'h0C3);
		rd(8'h0C, 4'h1);
		chk(r[8:0], 32'h0C3);
		chk(receive_fifo_not_empty, 32'h0);
	endtask : t_rx
	task automatic frame(input logic own, input logic good, input logic [2:0] e);
		frame_own = own;
		frame_ok = good;
		frame_end = 1'b1;
		step();
		frame_end = 1'b0;
		step();
		chk(signal_free_time, e);
	endtask : frame
	task automatic t_sft;
		frame(1'b1, 1'b1, 3'h7);
		frame(1'b1, 1'b0, 3'h3);
		frame(1'b0, 1'b0, 3'h5);
		frame(1'b1, 1'b1, 3'h7);
		wr(8'h00, 4'hF, 32'h9);
		chk(signal_free_time, 32'h5);
		bus_idle = 1'b1;
		step(2);
		chk(signal_free_time, 32'h7);
		rd(8'h00);
		chk(r, 32'h1);
		bus_idle = 1'b0;
		step();
		bus_idle = 1'b1;
		wr(8'h00, 4'hF, 32'h9);
		rd(8'h00);
		chk(r, 32'h9);
	endtask : t_sft
	task automatic t_srst;
		i_cbc_far_model.stall = 1'b1;
		wr(8'h08, 4'hF, 32'h1AA);
		chk(tx_valid, 32'h1);
		reg_addr = 8'h00;
		reg_be = 4'hF;
		reg_wdata = 32'h3;
		reg_wr = 1'b1;
		step();
		reg_wr = 1'b0;
		chk(engine_reset, 32'h1);
		step();
		chk(engine_reset, 32'h0);
		chk(tx_valid, 32'h0);
		chk(rx_ready, 32'h0);
		chk(clock_gate_n, 32'h0);
		i_cbc_far_model.stall = 1'b0;
		rd(8'h00);
		chk(r, 32'h0);
		rd(8'h04);
		chk(r, 32'h0);
		chk(block_active, 32'h0);
	endtask : t_srst
	// Main sequence
	initial begin
		repeat (16) @(posedge mclk);
		#2;
		nrst = 1'b1;
		step();
		t_reset();
		t_ctrl();
		t_claim();
		t_tx();
		t_rx();
		t_sft();
		t_srst();
		results();
	end
endmodule : cbc_ctrl_regs_tb_top

/* File: bench/cbc_far_model.sv */
/*
 * Far-side model of the bus engine: drains the transmit FIFO and fills the receive FIFO.
 * Assumes valid/ready transfers on mclk; the bench stalls the drain through stall.
 */
`timescale 1ns/1ps
module cbc_far_model (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Transmit drain
	input wire logic tx_valid,
	output logic tx_ready,
	input wire cbc_pkg::cbc_block_s tx_block,
	// Receive fill
	output logic rx_valid,
	input wire logic rx_ready,
	output cbc_pkg::cbc_block_s rx_block
);
	logic stall = 1'b0;
	cbc_pkg::cbc_block_s got[$];
	// Drain side takes a block only when not stalled
	assign tx_ready = !stall;
	always @(posedge mclk) begin
		if (nrst && tx_valid && tx_ready) got.push_back(tx_block);
	end
	initial begin
		rx_valid = 1'b0;
		rx_block = 9'h000;
	end
	// Offer one block, hold it until taken or 20 edges pass, then show scrambled data
	task automatic send(input cbc_pkg::cbc_block_s b, output logic ok);
		int n;
		n = 0;
		rx_valid = 1'b1;
		rx_block = b;
		while (!rx_ready && n < 20) begin
			@(posedge mclk);
			#2;
			n++;
		end
		ok = rx_ready;
		@(posedge mclk);
		#2;
		rx_valid = 1'b0;
		rx_block = ~b;
		// Let an edge pass so a following offer never meets this release
		@(posedge mclk);
		#2;
	endtask : send
endmodule : cbc_far_model

/* File: inc/cbc_pkg.sv */
/*
 * Types of the control bus front end.
 * Assumes cbc_regs.svh for the numeric constants.
 */
package cbc_pkg;
	// One bus block with its end flag
	typedef struct packed {
		logic end_of_message_flag;
		logic [7:0] data;
	} cbc_block_s;
	// Outcome of the last frame, selects the free time
	typedef enum logic [1:0] {
		CBC_LAST_RESET,
		CBC_LAST_OWN_FAIL,
		CBC_LAST_OWN_OK,
		CBC_LAST_OTHER
	} cbc_last_e;
endpackage : cbc_pkg

/* File: inc/cbc_regs.svh */
/*
 * Register offsets, field positions, reset values and timing constants of the control bus front end.
 * Assumes a 32-bit register port with byte strobes, addressed by byte offset.
 */
`ifndef CBC_REGS_SVH
`define CBC_REGS_SVH
`define CBC_OFS_CONTROL 8'h00
`define CBC_OFS_CLAIMED 8'h04
`define CBC_OFS_TXPORT 8'h08
`define CBC_OFS_RXPORT 8'h0C
`define CBC_BIT_ACTIVE 0
`define CBC_BIT_SOFTRST 1
`define CBC_BIT_FILTER 2
`define CBC_BIT_OVERRIDE 3
`define CBC_BIT_END_FLAG 8
`define CBC_DATA_HI 7
`define CBC_CONTROL_RESET 4'h0
`define CBC_CLAIMED_RESET 16'h0000
`define CBC_FREE_SHORT 3'h3
`define CBC_FREE_MID 3'h5
`define CBC_FREE_LONG 3'h7
`define CBC_FIFO_DEPTH 16
`define CBC_FIFO_AW 4
`define CBC_FILTER_LEN 2'h3
`endif

/* File: rtl/cbc_ctrl_regs.sv */
/*
 * Control and data-path registers of the single-wire control bus controller.
 * Assumes firmware on a byte-strobed register port, and bit engines outside that report bus idle and frame ends.
 */
`timescale 1ns/1ps
`include "cbc_regs.svh"
// Functional notes
// - Override bit forces free time five once
// - Override clears when bus idle asserts
// - Control bit 2 enables line filtering
// - Soft reset returns all state but read data and line synchroniser/filter flops to default
// - Soft reset bit clears itself next cycle
// - Control bit 0 enables, else lowest power
// - Claimed address is read-only one-hot
// - Header nibbles select initiator/follower address bits
// - Transmit write pushes byte plus end flag
// - End flag one marks last block
// - Transmit register reads back zero
// - Receive read returns oldest entry, flag bit8
// - Receive read when empty is undefined
// - Free time three, five or seven periods
// - Zero claimed address decodes no frames
module cbc_ctrl_regs (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [3:0] reg_be,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	output logic tx_port_ready,
	// Claimed address load from bus engine
	input wire logic claim_load,
	input wire logic [3:0] claim_index,
	input wire logic [7:0] header_byte,
	output logic header_to_us,
	// Bus engine status
	input wire logic bus_idle,
	input wire logic frame_end,
	input wire logic frame_own,
	input wire logic frame_ok,
	input wire logic raw_line,
	// Controls to bus engine
	output logic block_active,
	output logic clock_gate_n,
	output logic engine_reset,
	output logic follower_enable,
	output logic line_filtered,
	output logic [2:0] signal_free_time,
	// Transmit FIFO drain
	output logic tx_valid,
	input wire logic tx_ready,
	output cbc_pkg::cbc_block_s tx_block,
	// Receive FIFO fill
	input wire logic rx_valid,
	output logic rx_ready,
	input wire cbc_pkg::cbc_block_s rx_block,
	output logic receive_fifo_not_empty
);
	logic active, line_filter_enable, free_time_override, soft_reset;
	logic next_active, next_filter, next_override, next_soft_reset;
	logic end_flag_hold, next_end_flag_hold, rx_room;
	logic [2:0] next_free_time;
	logic [15:0] claimed_address_onehot, next_claimed;
	cbc_pkg::cbc_last_e last, next_last;
	logic idle_q, next_idle_q;
	logic line_s1, line_s2, next_line_s1, next_line_s2;
	logic [1:0] flt_cnt, next_flt_cnt;
	logic flt_line, next_flt_line;
	logic [31:0] next_rdata;
	logic ctl_wr, tx_wr, rx_rd, tx_push;
	logic rx_valid_o;
	cbc_pkg::cbc_block_s rx_head, tx_in;

	// Access decode; byte accesses act on the low lane
	always_comb begin
		ctl_wr = 1'b0;
		tx_wr = 1'b0;
		rx_rd = 1'b0;
		if (reg_wr && reg_addr == `CBC_OFS_CONTROL && reg_be[0]) begin
			ctl_wr = 1'b1;
		end else if (reg_wr && reg_addr == `CBC_OFS_TXPORT && reg_be[0]) begin
			tx_wr = 1'b1;
		end
		if (reg_rd && reg_addr == `CBC_OFS_RXPORT && reg_be[0]) begin
			rx_rd = 1'b1;
		end
	end

	// Transmit entry; a low-lane-only write takes the flag held from the upper-lane write
	always_comb begin
		next_end_flag_hold = end_flag_hold;
		tx_in.data = reg_wdata[`CBC_DATA_HI:0];
		if (reg_be[1]) begin
			tx_in.end_of_message_flag = reg_wdata[`CBC_BIT_END_FLAG];
		end else begin
			tx_in.end_of_message_flag = end_flag_hold;
		end
		if (soft_reset) begin
			next_end_flag_hold = 1'b0;
		end else if (reg_wr && reg_addr == `CBC_OFS_TXPORT && reg_be[1]) begin
			next_end_flag_hold = reg_wdata[`CBC_BIT_END_FLAG];
		end
		tx_push = tx_wr && block_active;
	end

	// Held end flag, kept until the next upper-lane write or a soft reset
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			end_flag_hold <= 1'b0;
		end else begin
			end_flag_hold <= next_end_flag_hold;
		end
	end

	// Control state next values
	always_comb begin
		next_active = active;
		next_filter = line_filter_enable;
		next_override = free_time_override;
		next_soft_reset = 1'b0;
		next_idle_q = bus_idle;
		next_last = last;
		next_claimed = claimed_address_onehot;
		if (soft_reset) begin
			next_active = 1'b0;
			next_filter = 1'b0;
			next_override = 1'b0;
			next_idle_q = 1'b1;
			next_last = cbc_pkg::CBC_LAST_RESET;
			next_claimed = `CBC_CLAIMED_RESET;
		end else begin
			// Idle rising edge ends the one-shot
			if (bus_idle && !idle_q) begin
				next_override = 1'b0;
			end
			// A write landing on the idle edge still arms it
			if (ctl_wr) begin
				next_active = reg_wdata[`CBC_BIT_ACTIVE];
				next_filter = reg_wdata[`CBC_BIT_FILTER];
				next_soft_reset = reg_wdata[`CBC_BIT_SOFTRST];
				if (reg_wdata[`CBC_BIT_OVERRIDE]) begin
					next_override = 1'b1;
				end
			end
			if (frame_end) begin
				if (!frame_own) begin
					next_last = cbc_pkg::CBC_LAST_OTHER;
				end else if (frame_ok) begin
					next_last = cbc_pkg::CBC_LAST_OWN_OK;
				end else begin
					next_last = cbc_pkg::CBC_LAST_OWN_FAIL;
				end
			end
			if (claim_load) begin
				next_claimed = 16'h0001 << claim_index;
			end
		end
	end

	// Control state registers
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			active <= 1'b0;
			line_filter_enable <= 1'b0;
			free_time_override <= 1'b0;
			soft_reset <= 1'b0;
			idle_q <= 1'b1;
			last <= cbc_pkg::CBC_LAST_RESET;
			claimed_address_onehot <= `CBC_CLAIMED_RESET;
		end else begin
			active <= next_active;
			line_filter_enable <= next_filter;
			free_time_override <= next_override;
			soft_reset <= next_soft_reset;
			idle_q <= next_idle_q;
			last <= next_last;
			claimed_address_onehot <= next_claimed;
		end
	end

	// Free time selection and engine controls
	always_comb begin
		case (last)
			cbc_pkg::CBC_LAST_OWN_FAIL: next_free_time = `CBC_FREE_SHORT;
			cbc_pkg::CBC_LAST_OWN_OK: next_free_time = `CBC_FREE_LONG;
			default: next_free_time = `CBC_FREE_MID;
		endcase
		if (free_time_override) begin
			next_free_time = `CBC_FREE_MID;
		end
		block_active = active;
		clock_gate_n = active;
		engine_reset = soft_reset;
		follower_enable = active && (claimed_address_onehot != '0);
		header_to_us = follower_enable && (claimed_address_onehot[header_byte[3:0]]
			|| claimed_address_onehot[header_byte[7:4]]);
	end

	// Free time register, so the engine sees a flop output
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			signal_free_time <= `CBC_FREE_MID;
		end else begin
			signal_free_time <= next_free_time;
		end
	end

	// Line synchroniser and glitch filter
	always_comb begin
		next_line_s1 = raw_line;
		next_line_s2 = line_s1;
		next_flt_cnt = flt_cnt;
		next_flt_line = flt_line;
		if (!line_filter_enable) begin
			next_flt_line = line_s2;
			next_flt_cnt = '0;
		end else if (line_s2 == flt_line) begin
			next_flt_cnt = '0;
		end else if (flt_cnt == `CBC_FILTER_LEN) begin
			next_flt_line = line_s2;
			next_flt_cnt = '0;
		end else begin
			next_flt_cnt = flt_cnt + 2'h1;
		end
		line_filtered = flt_line;
	end

	// Filter registers
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			line_s1 <= 1'b1;
			line_s2 <= 1'b1;
			flt_cnt <= '0;
			flt_line <= 1'b1;
		end else begin
			line_s1 <= next_line_s1;
			line_s2 <= next_line_s2;
			flt_cnt <= next_flt_cnt;
			flt_line <= next_flt_line;
		end
	end

	// Transmit FIFO, drained by the initiator engine
	cbc_fifo #(.WIDTH(9), .DEPTH(`CBC_FIFO_DEPTH), .AW(`CBC_FIFO_AW)) u_tx_fifo (
		.mclk(mclk),
		.nrst(nrst),
		.flush(soft_reset),
		.in_valid(tx_push),
		.in_ready(tx_port_ready),
		.in_data(tx_in),
		.out_valid(tx_valid),
		.out_ready(tx_ready),
		.out_data(tx_block)
	);

	// Receive FIFO, drained by register reads
	cbc_fifo #(.WIDTH(9), .DEPTH(`CBC_FIFO_DEPTH), .AW(`CBC_FIFO_AW)) u_rx_fifo (
		.mclk(mclk),
		.nrst(nrst),
		.flush(soft_reset),
		.in_valid(rx_valid && active),
		.in_ready(rx_room),
		.in_data(rx_block),
		.out_valid(rx_valid_o),
		.out_ready(rx_rd),
		.out_data(rx_head)
	);
	assign receive_fifo_not_empty = rx_valid_o;
	// Far side sees ready only while the block takes blocks
	assign rx_ready = rx_room && active;

	// Read data, registered one cycle after the read strobe
	always_comb begin
		next_rdata = '0;
		if (reg_addr == `CBC_OFS_CONTROL) begin
			next_rdata[`CBC_BIT_OVERRIDE] = free_time_override;
			next_rdata[`CBC_BIT_FILTER] = line_filter_enable;
			next_rdata[`CBC_BIT_SOFTRST] = soft_reset;
			next_rdata[`CBC_BIT_ACTIVE] = active;
		end else if (reg_addr == `CBC_OFS_CLAIMED) begin
			next_rdata[15:0] = claimed_address_onehot;
		end else if (reg_addr == `CBC_OFS_TXPORT) begin
			next_rdata = '0;
		end else if (reg_addr == `CBC_OFS_RXPORT) begin
			next_rdata[8:0] = rx_head;
		end
		if (!reg_rd) begin
			next_rdata = reg_rdata;
		end
	end

	// Read data register
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= next_rdata;
		end
	end

	// Soft reset lasts exactly one cycle
	soft_self_clear_a: assert property (@(posedge mclk) disable iff (!nrst)
		soft_reset |=> !soft_reset) else $error("soft reset stuck");
	// Control write with reset bit starts soft reset
	soft_start_a: assert property (@(posedge mclk) disable iff (!nrst)
		(ctl_wr && !soft_reset && reg_wdata[`CBC_BIT_SOFTRST]) |=> soft_reset) else $error("no soft reset");
	// Soft reset clears controls
	soft_default_a: assert property (@(posedge mclk) disable iff (!nrst)
		soft_reset |=> (!active && !line_filter_enable && claimed_address_onehot == '0)) else $error("bad default");
	// Soft reset empties both FIFOs
	soft_flush_a: assert property (@(posedge mclk) disable iff (!nrst)
		soft_reset |=> (!tx_valid && !receive_fifo_not_empty)) else $error("FIFO kept data");
	sequence idle_rise_s;
		bus_idle && !idle_q;
	endsequence
	sequence override_write_s;
		ctl_wr && !soft_reset && reg_wdata[`CBC_BIT_OVERRIDE];
	endsequence
	// Override drops after idle unless rearmed in that cycle
	override_clear_a: assert property (@(posedge mclk) disable iff (!nrst)
		idle_rise_s ##0 (!soft_reset && !(ctl_wr && reg_wdata[`CBC_BIT_OVERRIDE])) |=> !free_time_override)
		else $error("override kept");
	// Override write arms the one-shot, even on the idle edge
	override_set_a: assert property (@(posedge mclk) disable iff (!nrst)
		override_write_s |=> free_time_override) else $error("override not set");
	// Override selects five
	override_five_a: assert property (@(posedge mclk) disable iff (!nrst)
		free_time_override |=> signal_free_time == `CBC_FREE_MID) else $error("override ignored");
	// Successful own frame gives seven
	free_seven_a: assert property (@(posedge mclk) disable iff (!nrst)
		(frame_end && frame_own && frame_ok && !soft_reset) ##1 !free_time_override
		|=> signal_free_time == `CBC_FREE_LONG) else $error("free time not seven");
	// Claimed field one-hot
	claim_onehot_a: assert property (@(posedge mclk) disable iff (!nrst)
		$onehot0(claimed_address_onehot)) else $error("claimed not one-hot");
	// No follower without address
	follower_gate_a: assert property (@(posedge mclk) disable iff (!nrst)
		(claimed_address_onehot == '0) |-> !follower_enable) else $error("follower on");
	// Transmit readback zero
	tx_read_zero_a: assert property (@(posedge mclk) disable iff (!nrst)
		(reg_rd && reg_addr == `CBC_OFS_TXPORT) |=> reg_rdata == '0) else $error("tx readback");
	// Disabled block gates its clock and refuses blocks
	power_gate_a: assert property (@(posedge mclk) disable iff (!nrst)
		!active |-> !clock_gate_n && !follower_enable && !rx_ready) else $error("not low power");
endmodule : cbc_ctrl_regs

/* File: rtl/cbc_fifo.sv */
/*
 * Parameterised synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and an asynchronous active-low reset plus a synchronous flush.
 */
`timescale 1ns/1ps
module cbc_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	input wire logic flush,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wptr, rptr, next_wptr, next_rptr;
	logic [AW:0] count, next_count;
	logic push, pop;

	// Handshakes and pointer updates
	always_comb begin
		in_ready = (count != (AW+1)'(DEPTH));
		out_valid = (count != '0);
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		next_wptr = flush ? '0 : wptr + AW'(push);
		next_rptr = flush ? '0 : rptr + AW'(pop);
		next_count = flush ? '0 : count + (AW+1)'(push) - (AW+1)'(pop);
		out_data = mem[rptr];
	end

	// Pointer registers
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			wptr <= '0;
			rptr <= '0;
			count <= '0;
		end else begin
			wptr <= next_wptr;
			rptr <= next_rptr;
			count <= next_count;
		end
	end

	// Storage array
	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wptr] <= in_data;
		end
	end
endmodule : cbc_fifo
